/* core/console_io_pkg.sv */
/*
  Constants shared by the console I/O and refresh control block:
  I/O addresses, field positions, reset values and refresh timing.
  Assumes a 20 MHz console clock.
*/
package console_io_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int clock_mhz = 20;
  localparam real refresh_period_us = 12.8;
  localparam int refresh_period_cycles =
    int'(refresh_period_us * clock_mhz);
  localparam int refresh_high_cycles = refresh_period_cycles / 2;
  localparam int refresh_cnt_width = $clog2(refresh_period_cycles);
  localparam int row_width = 7;
  localparam int step_width = 2;

  // ---------------------------------------------------------------
  // I/O addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] upc_shift_status = 8'h00;
  localparam logic [7:0] misc_boot_status = 8'h01;
  localparam logic [7:0] bus_dclow_halt_status = 8'h02;
  localparam logic [7:0] ctrlp_disable_status = 8'h03;
  localparam logic [7:0] self_test_switch_status = 8'h04;
  localparam logic [7:0] supply5_carrier_status = 8'h05;
  localparam logic [7:0] slow_clock_remote_status = 8'h06;
  localparam logic [7:0] supply15_ring_status = 8'h07;
  localparam logic [7:0] cstore_write_byte0 = 8'h08;
  localparam logic [7:0] cstore_write_byte1 = 8'h09;
  localparam logic [7:0] cstore_write_byte2 = 8'h0a;
  localparam logic [7:0] interval_timer_data_port = 8'h1c;
  localparam logic [7:0] interval_timer_cmd_port = 8'h1d;
  localparam logic [7:0] ready_summary = 8'h20;
  localparam logic [7:0] cpu_run_clear = 8'h20;
  localparam logic [7:0] cpu_run_set = 8'h21;
  localparam logic [7:0] cpu_step_clear = 8'h22;
  localparam logic [7:0] cpu_step_set = 8'h23;
  localparam logic [7:0] csreg_step_clear = 8'h24;
  localparam logic [7:0] csreg_step_set = 8'h25;
  localparam logic [7:0] upc_step_clear = 8'h26;
  localparam logic [7:0] upc_step_set = 8'h27;
  localparam logic [7:0] memctl_ctl0_clear = 8'h28;
  localparam logic [7:0] memctl_ctl0_set = 8'h29;
  localparam logic [7:0] memctl_ctl1_clear = 8'h2a;
  localparam logic [7:0] memctl_ctl1_set = 8'h2b;
  localparam logic [7:0] timer_start_clear = 8'h2c;
  localparam logic [7:0] timer_start_set = 8'h2d;
  localparam logic [7:0] bus_busy_clear = 8'h2e;
  localparam logic [7:0] bus_busy_set = 8'h2f;
  localparam logic [7:0] bus_dclow_set = 8'h30;
  localparam logic [7:0] bus_dclow_clear = 8'h31;
  localparam logic [7:0] bus_aclow_set = 8'h32;
  localparam logic [7:0] bus_aclow_clear = 8'h33;
  localparam logic [7:0] bus_init_clear = 8'h34;
  localparam logic [7:0] bus_init_set = 8'h35;
  localparam logic [7:0] cstore_write_end = 8'h36;
  localparam logic [7:0] cstore_write_begin = 8'h37;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int upc_bit = 14;
  localparam int status_hi_bit = 7;
  localparam logic [7:0] undefined_read = 8'hff;
  localparam logic [23:0] cstore_data_reset = 24'h000000;
  localparam logic [7:0] summary_reset = 8'h00;

  typedef enum logic [1:0] {
    cyc_idle = 2'b00,
    cyc_refresh = 2'b01,
    cyc_access = 2'b10,
    cyc_done = 2'b11
  } cycle_state_t;

endpackage

/* core/step_link_if.sv */
/*
  Carrier for the single-step enable set and clear strobes between
  the decoder and the step flip-flop module.
  Assumes one console clock domain.
*/
`timescale 1ns/1ns
interface step_link_if;
  logic [console_io_pkg::step_width:0] set_strobe;
  logic [console_io_pkg::step_width:0] clear_strobe;
  logic [console_io_pkg::step_width:0] enable;
  modport decoder (output set_strobe, output clear_strobe, input enable);
  modport flops (input set_strobe, input clear_strobe, output enable);
endinterface

/* core/step_flops.sv */
/*
  Holds the three single-step enables: CPU clocks, control-store
  register clock and microprogram counter clock.
  Assumes strobes are one-cycle pulses on the console clock.
*/
`timescale 1ns/1ns
module step_flops
  import console_io_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  step_link_if.flops link
);
  typedef struct packed {
    logic [step_width:0] enable;
  } step_state_t;

  step_state_t state;
  step_state_t next_state;

  always_comb
  begin
    next_state = state;
    // Set wins when both strobes arrive together
    next_state.enable = (state.enable & ~link.clear_strobe)
      | link.set_strobe;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state <= '0;
    else
      state <= next_state;
  end

  assign link.enable = state.enable;
endmodule // step_flops

/* core/console_io_refresh_control.sv */
/*
  Console I/O map decode and console RAM refresh arbitration.
  Assumes the console processor presents a latched I/O or memory
  cycle (start pulse, address, read/write strobes) on this clock and
  holds one cycle at a time; pins from outside are synchronised here.
*/
`timescale 1ns/1ns
// Behaviour
// - Refresh waits while a serial-controller access is in progress.
// - Pending refresh at RAM access start keeps cycle start and long cycle.
// - RAM read or write follows the refresh inside the same cycle.
// - Sync flop set by refresh flag, cleared when request falls.
// - Control-store refresh starts on falling edge of the sync flop.
// - Address 00 reads microprogram counter bit 14 on data bit 7.
// - Writes 08, 09, 0A load control-store write data bytes.
// - 1C is timer data port, 1D timer command/status port.
// - Read 20 returns the ready summary byte.
// - Writes 22 to 27 clear or set three single-step enables.
// - Write 2C stops the interval timer, 2D starts it.
// - Write 34 clears console bus init, 35 asserts it.
// - Write 37 begins control-store write, 36 ends it.
// - 28 to 2B drive spare flops; 0B-1B, 1E, 1F unused.
// - Refresh request every 12.8 us; rising edge sets refresh flag.
// - Refresh drives 7-bit row counter, one strobe, increments after.
module console_io_refresh_control
  import console_io_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic cycle_start,
  input wire logic [7:0] io_address,
  input wire logic is_io,
  input wire logic is_ram,
  input wire logic is_usart,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic [7:0] write_data,
  input wire logic upc_bit14_pin,
  input wire logic [7:0] status_hi_pins,
  input wire logic [7:0] status_lo_pins,
  input wire logic [7:0] ready_pins,
  input wire logic [7:0] timer_read_data,
  output logic [7:0] read_data,
  output logic ready,
  output logic long_cycle,
  output logic start_cycle_ff,
  output logic refresh_cycle_flag,
  output logic refresh_sync_ff,
  output logic [row_width-1:0] refresh_row,
  output logic refresh_row_strobe,
  output logic ram_access_strobe,
  output logic cstore_refresh_start,
  output logic [23:0] cstore_write_data,
  output logic timer_data_select,
  output logic timer_cmd_select,
  output logic cpu_run,
  output logic [step_width:0] single_step_enable,
  output logic [1:0] memctl_spare_control,
  output logic interval_timer_run,
  output logic bus_busy_line,
  output logic dc_power_low_line,
  output logic ac_power_low_line,
  output logic console_bus_init,
  output logic cstore_write_active
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [refresh_cnt_width-1:0] divider;
    logic request;
    logic request_last;
    logic pending;
    logic flag;
    logic sync_ff;
    logic cs_start;
    logic [row_width-1:0] row;
    logic row_strobe;
    cycle_state_t cyc;
    logic ram_strobe;
    logic usart_busy;
    logic ready;
    logic long_cycle;
    logic start_ff;
    logic [7:0] read_data;
    logic [23:0] cs_data;
    logic timer_data_sel;
    logic timer_cmd_sel;
    logic cpu_run;
    logic [1:0] spare;
    logic timer_run;
    logic busy;
    logic dc_low;
    logic ac_low;
    logic init;
    logic cs_write;
    logic [1:0] upc_sync;
    logic [7:0] hi_meta;
    logic [7:0] hi_sync;
    logic [7:0] lo_meta;
    logic [7:0] lo_sync;
    logic [7:0] rdy_meta;
    logic [7:0] rdy_sync;
  } state_t;

  state_t state;
  state_t next_state;
  step_link_if step_link ();

  step_flops u_step_flops
  (
    .clock(clock),
    .reset(reset),
    .link(step_link.flops)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic wr;
    logic rd;
    logic io_busy;
    wr = write_strobe & is_io;
    rd = read_strobe & is_io;
    io_busy = 1'b0;
    next_state = state;
    step_link.set_strobe = '0;
    step_link.clear_strobe = '0;

    // Pin synchronisers
    next_state.upc_sync = {state.upc_sync[0], upc_bit14_pin};
    next_state.hi_meta = status_hi_pins;
    next_state.hi_sync = state.hi_meta;
    next_state.lo_meta = status_lo_pins;
    next_state.lo_sync = state.lo_meta;
    next_state.rdy_meta = ready_pins;
    next_state.rdy_sync = state.rdy_meta;

    // Free-running request, half period high
    // Fixed period; the serial baud dividers live outside this block
    if (state.divider ==
      refresh_cnt_width'(refresh_period_cycles - 1))
      next_state.divider = '0;
    else
      next_state.divider = state.divider + 1'b1;
    next_state.request = state.divider <
      refresh_cnt_width'(refresh_high_cycles);
    next_state.request_last = state.request;

    // Serial access blocks refresh start
    if (cycle_start & is_usart)
      next_state.usart_busy = 1'b1;
    else if (state.usart_busy & ~read_strobe & ~write_strobe
      & ~state.long_cycle)
      next_state.usart_busy = 1'b0;
    // A refresh-extended cycle must let its own refresh run, else the
    // serial access and the refresh state would wait on each other
    io_busy = (state.usart_busy & (state.cyc != cyc_refresh))
      | (state.cyc == cyc_access);

    // Refresh flag: one row strobe, counter bumped at trailing edge
    next_state.row_strobe = 1'b0;
    if (state.flag)
    begin
      next_state.flag = 1'b0;
      next_state.row = state.row + 1'b1;
    end
    else if (state.pending & ~io_busy)
    begin
      next_state.flag = 1'b1;
      next_state.row_strobe = 1'b1;
      next_state.pending = 1'b0;
    end

    // Rising edge latched only while the sync flop is clear; it comes
    // after the clear above so that a new request edge is never lost
    if (state.request & ~state.request_last & ~state.sync_ff)
      next_state.pending = 1'b1;

    // Sync flop and control-store refresh edge
    if (state.flag)
      next_state.sync_ff = 1'b1;
    else if (~state.request)
      next_state.sync_ff = 1'b0;
    // One-cycle pulse; the control store times its own refresh from it
    next_state.cs_start = state.sync_ff & ~next_state.sync_ff;

    // RAM and serial long cycles
    next_state.ram_strobe = 1'b0;
    unique case (state.cyc)
      cyc_idle:
      begin
        if (cycle_start & (is_ram | is_usart))
        begin
          next_state.start_ff = 1'b1;
          next_state.long_cycle = 1'b1;
          next_state.ready = 1'b0;
          // Refresh first when one is pending or under way
          if (state.pending | state.flag)
            next_state.cyc = cyc_refresh;
          else
            next_state.cyc = cyc_access;
        end
      end
      cyc_refresh:
      begin
        // Extra wait state; start flop held until refresh done
        if (~state.flag & ~state.pending)
          next_state.cyc = cyc_access;
      end
      cyc_access:
      begin
        next_state.ram_strobe = is_ram;
        next_state.cyc = cyc_done;
      end
      cyc_done:
      begin
        next_state.start_ff = 1'b0;
        next_state.long_cycle = 1'b0;
        next_state.ready = 1'b1;
        next_state.cyc = cyc_idle;
      end
    endcase

    // Timer selects follow address for whole I/O cycle
    next_state.timer_data_sel = is_io
      & (io_address == interval_timer_data_port);
    next_state.timer_cmd_sel = is_io
      & (io_address == interval_timer_cmd_port);

    // Read mux; unmapped and write-only addresses float high
    // Status pins lag two clocks, so a read right after a change is old
    next_state.read_data = undefined_read;
    if (rd)
    begin
      unique case (io_address)
        upc_shift_status:
          next_state.read_data = {state.upc_sync[1], 7'h00};
        misc_boot_status, bus_dclow_halt_status, ctrlp_disable_status,
        self_test_switch_status, supply5_carrier_status,
        slow_clock_remote_status, supply15_ring_status:
          next_state.read_data = {state.hi_sync[io_address[2:0]], 6'h00,
            state.lo_sync[io_address[2:0]]};
        interval_timer_data_port, interval_timer_cmd_port:
          next_state.read_data = timer_read_data;
        ready_summary:
          next_state.read_data = state.rdy_sync;
        default:
          next_state.read_data = undefined_read;
      endcase
    end

    // Command strobes; data ignored except control-store bytes
    if (wr)
    begin
      unique case (io_address)
        cstore_write_byte0: next_state.cs_data[7:0] = write_data;
        cstore_write_byte1: next_state.cs_data[15:8] = write_data;
        cstore_write_byte2: next_state.cs_data[23:16] = write_data;
        cpu_run_clear: next_state.cpu_run = 1'b0;
        cpu_run_set: next_state.cpu_run = 1'b1;
        cpu_step_clear: step_link.clear_strobe[0] = 1'b1;
        cpu_step_set: step_link.set_strobe[0] = 1'b1;
        csreg_step_clear: step_link.clear_strobe[1] = 1'b1;
        csreg_step_set: step_link.set_strobe[1] = 1'b1;
        upc_step_clear: step_link.clear_strobe[2] = 1'b1;
        upc_step_set: step_link.set_strobe[2] = 1'b1;
        memctl_ctl0_clear: next_state.spare[0] = 1'b0;
        memctl_ctl0_set: next_state.spare[0] = 1'b1;
        memctl_ctl1_clear: next_state.spare[1] = 1'b0;
        memctl_ctl1_set: next_state.spare[1] = 1'b1;
        timer_start_clear: next_state.timer_run = 1'b0;
        timer_start_set: next_state.timer_run = 1'b1;
        bus_busy_clear: next_state.busy = 1'b0;
        bus_busy_set: next_state.busy = 1'b1;
        bus_dclow_set: next_state.dc_low = 1'b1;
        bus_dclow_clear: next_state.dc_low = 1'b0;
        bus_aclow_set: next_state.ac_low = 1'b1;
        bus_aclow_clear: next_state.ac_low = 1'b0;
        bus_init_clear: next_state.init = 1'b0;
        bus_init_set: next_state.init = 1'b1;
        cstore_write_end: next_state.cs_write = 1'b0;
        cstore_write_begin: next_state.cs_write = 1'b1;
        default: next_state.cpu_run = state.cpu_run;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state <= '0;
      // Ready idles high so the first cycle after reset is not stretched
      state.ready <= 1'b1;
      state.read_data <= undefined_read;
      state.cs_data <= cstore_data_reset;
      state.rdy_sync <= summary_reset;
    end
    else
      state <= next_state;
  end

  // ---------------------------------------------------------------
  // Outputs, all flop driven
  // ---------------------------------------------------------------
  assign read_data = state.read_data;
  assign ready = state.ready;
  assign long_cycle = state.long_cycle;
  assign start_cycle_ff = state.start_ff;
  assign refresh_cycle_flag = state.flag;
  assign refresh_sync_ff = state.sync_ff;
  assign refresh_row = state.row;
  assign refresh_row_strobe = state.row_strobe;
  assign ram_access_strobe = state.ram_strobe;
  assign cstore_refresh_start = state.cs_start;
  assign cstore_write_data = state.cs_data;
  assign timer_data_select = state.timer_data_sel;
  assign timer_cmd_select = state.timer_cmd_sel;
  assign cpu_run = state.cpu_run;
  assign single_step_enable = step_link.enable;
  assign memctl_spare_control = state.spare;
  assign interval_timer_run = state.timer_run;
  assign bus_busy_line = state.busy;
  assign dc_power_low_line = state.dc_low;
  assign ac_power_low_line = state.ac_low;
  assign console_bus_init = state.init;
  assign cstore_write_active = state.cs_write;

endmodule // console_io_refresh_control

/* dv/console_io_properties.sv */
/*
  Checker for the console I/O map and RAM refresh arbitration.
  Assumes it is bound to the top module and sees one clock domain.
*/
`timescale 1ns/1ns
module console_io_checker
  import console_io_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic cycle_start,
  input wire logic [7:0] io_address,
  input wire logic is_io,
  input wire logic is_ram,
  input wire logic is_usart,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic ready,
  input wire logic long_cycle,
  input wire logic start_cycle_ff,
  input wire logic refresh_cycle_flag,
  input wire logic refresh_sync_ff,
  input wire logic [row_width-1:0] refresh_row,
  input wire logic refresh_row_strobe,
  input wire logic ram_access_strobe,
  input wire logic cstore_refresh_start,
  input wire logic cpu_run
);
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire logic io_wr = is_io && write_strobe;
  wire logic usart_busy = is_usart && (read_strobe || write_strobe);
  wire logic run_wr = io_wr && io_address[7:1] == 7'h10;

  property p_ram_wait;
    cycle_start && is_ram |=> !ready && long_cycle && start_cycle_ff;
  endproperty
  a_ram_wait: assert property (p_ram_wait) else $error("no wait");
  property p_ram_done;
    cycle_start && is_ram |-> ##[1:12] ram_access_strobe;
  endproperty
  a_ram_done: assert property (p_ram_done) else $error("no access");
  property p_after_ref;
    refresh_cycle_flag && start_cycle_ff && is_ram
      |-> ##[1:6] ram_access_strobe && !ready;
  endproperty
  a_after_ref: assert property (p_after_ref) else $error("late");
  property p_usart_hold;
    usart_busy && $past(usart_busy) && !$past(cycle_start)
      |-> !$rose(refresh_cycle_flag);
  endproperty
  a_usart_hold: assert property (p_usart_hold) else $error("usart");
  property p_flag_sync;
    refresh_cycle_flag |-> refresh_row_strobe ##[0:1] refresh_sync_ff;
  endproperty
  a_flag_sync: assert property (p_flag_sync) else $error("sync");
  property p_flag_pulse;
    refresh_cycle_flag |=> !refresh_cycle_flag [*8];
  endproperty
  a_flag_pulse: assert property (p_flag_pulse) else $error("flag");
  property p_cs_refresh;
    $fell(refresh_sync_ff) |-> ##[0:1] cstore_refresh_start;
  endproperty
  a_cs_refresh: assert property (p_cs_refresh) else $error("cs");
  property p_row_step;
    $changed(refresh_row) |-> refresh_row == $past(refresh_row) + 1'b1;
  endproperty
  a_row_step: assert property (p_row_step) else $error("row");
  property p_run;
    run_wr |=> cpu_run == $past(io_address[0]);
  endproperty
  a_run: assert property (p_run) else $error("run");
  c_ref: cover property (refresh_cycle_flag && long_cycle);
  c_cs: cover property (cstore_refresh_start);
  c_run: cover property (run_wr);
endmodule // console_io_checker

bind console_io_refresh_control console_io_checker chk_u (
  .clock, .reset, .cycle_start, .io_address, .is_io, .is_ram, .is_usart,
  .read_strobe, .write_strobe, .ready, .long_cycle, .start_cycle_ff,
  .refresh_cycle_flag, .refresh_sync_ff, .refresh_row, .refresh_row_strobe,
  .ram_access_strobe, .cstore_refresh_start, .cpu_run
);

/* dv/console_cpu_model.sv */
/*
  Console processor model: issues I/O, RAM and serial cycles.
  Assumes the bench calls its tasks; drives only at falling edges.
*/
`timescale 1ns/1ns
module console_cpu_model (
  input wire logic clock,
  input wire logic ready,
  input wire logic [7:0] read_data,
  output logic cycle_start,
  output logic [7:0] io_address,
  output logic is_io,
  output logic is_ram,
  output logic is_usart,
  output logic read_strobe,
  output logic write_strobe,
  output logic [7:0] write_data
);
  initial
  begin
    {cycle_start, is_io, is_ram, is_usart, read_strobe, write_strobe} = '0;
    io_address = 8'h00;
    write_data = 8'h00;
  end
  // Released bus lines show the inverse, never a stale value
  task automatic io_op(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
    @(negedge clock);
    cycle_start = 1'b1; is_io = 1'b1; io_address = a;
    @(negedge clock);
    cycle_start = 1'b0; write_strobe = wr; read_strobe = !wr; write_data = d;
    repeat (2) @(negedge clock);
    q = read_data;
    {is_io, read_strobe, write_strobe} = '0;
    io_address = ~a; write_data = ~d;
    @(negedge clock);
  endtask
  // One cycle at a time, held until ready returns
  task automatic mem_op(input logic ram, input int hold, output int low);
    int n;
    @(negedge clock);
    cycle_start = 1'b1; is_ram = ram; is_usart = !ram; is_io = !ram;
    io_address = 8'h48; read_strobe = 1'b1;
    @(negedge clock);
    cycle_start = 1'b0; low = 0; n = 0;
    while ((n < hold || !ready) && n < 300)
    begin
      low += int'(!ready);
      n++;
      @(negedge clock);
    end
    {is_ram, is_usart, is_io, read_strobe} = '0;
    io_address = 8'hb7;
    @(negedge clock);
  endtask
endmodule // console_cpu_model

/* dv/console_io_refresh_control_tb.sv */
/*
  Self-checking bench for the console I/O and refresh block.
  Assumes console_cpu_model as processor and a 20 MHz clock.
*/
`timescale 1ns/1ns
module console_io_refresh_control_tb;
  import console_io_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cycle_start, is_io, is_ram, is_usart, read_strobe, write_strobe;
  logic upc_bit14_pin, ready, long_cycle, start_cycle_ff, refresh_sync_ff;
  logic refresh_cycle_flag, refresh_row_strobe, ram_access_strobe;
  logic cstore_refresh_start, timer_data_select, timer_cmd_select, cpu_run;
  logic interval_timer_run, bus_busy_line, dc_power_low_line;
  logic ac_power_low_line, console_bus_init, cstore_write_active;
  logic [7:0] io_address, write_data, read_data, status_hi_pins;
  logic [7:0] status_lo_pins, ready_pins, timer_read_data;
  logic [row_width-1:0] refresh_row;
  logic [23:0] cstore_write_data;
  logic [step_width:0] single_step_enable;
  logic [1:0] memctl_spare_control;
  int n_errors = 0;
  int samples_checked = 0;

  always #25 clock = ~clock;

  console_io_refresh_control dut_u (.clock, .reset, .cycle_start,
    .io_address, .is_io, .is_ram, .is_usart, .read_strobe, .write_strobe,
    .write_data, .upc_bit14_pin, .status_hi_pins, .status_lo_pins,
    .ready_pins, .timer_read_data, .read_data, .ready, .long_cycle,
    .start_cycle_ff, .refresh_cycle_flag, .refresh_sync_ff, .refresh_row,
    .refresh_row_strobe, .ram_access_strobe, .cstore_refresh_start,
    .cstore_write_data, .timer_data_select, .timer_cmd_select, .cpu_run,
    .single_step_enable, .memctl_spare_control, .interval_timer_run,
    .bus_busy_line, .dc_power_low_line, .ac_power_low_line,
    .console_bus_init, .cstore_write_active);
  console_cpu_model cpu_u (.clock, .ready, .read_data, .cycle_start,
    .io_address, .is_io, .is_ram, .is_usart, .read_strobe, .write_strobe,
    .write_data);

  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [11:0] cmds();
    return {cstore_write_active, console_bus_init, ac_power_low_line,
      dc_power_low_line, bus_busy_line, interval_timer_run,
      memctl_spare_control, single_step_enable, cpu_run};
  endfunction
  // Cycles up to the next refresh flag, counting control-store starts
  task automatic gap(output int n, output int cs);
    n = 0;
    cs = 0;
    do
    begin
      @(negedge clock);
      n++;
      cs += int'(cstore_refresh_start);
    end
    while (!refresh_cycle_flag && n < 600);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_cmds;
    logic [7:0] q;
    logic [7:0] set_a [12] = '{8'h21, 8'h23, 8'h25, 8'h27, 8'h29, 8'h2b,
      8'h2d, 8'h2f, 8'h30, 8'h32, 8'h35, 8'h37};
    logic [7:0] clr_a [12] = '{8'h20, 8'h22, 8'h24, 8'h26, 8'h28, 8'h2a,
      8'h2c, 8'h2e, 8'h31, 8'h33, 8'h34, 8'h36};
    logic [23:0] e;
    chk({ready, read_data, cmds()}, {1'b1, 8'hff, 12'h000});
    for (int i = 0; i < 12; i++)
    begin
      cpu_u.io_op(1'b1, set_a[i], 8'h00, q);
      e = 24'((1 << (i + 1)) - 1);
      chk(24'(cmds()), e);
    end
    cpu_u.io_op(1'b1, 8'h10, 8'h00, q);
    cpu_u.io_op(1'b1, 8'h1e, 8'h00, q);
    chk(24'(cmds()), 24'hfff);
    for (int i = 0; i < 12; i++)
    begin
      cpu_u.io_op(1'b1, clr_a[i], 8'hff, q);
      e = 24'hfff & (24'hfff << (i + 1));
      chk(24'(cmds()), e);
    end
    cpu_u.io_op(1'b1, 8'h0a, 8'h3c, q);
    cpu_u.io_op(1'b1, 8'h08, 8'hc3, q);
    cpu_u.io_op(1'b1, 8'h09, 8'h5a, q);
    chk(cstore_write_data, 24'h3c5ac3);
    $display("t_cmds done");
  endtask
  task automatic t_reads;
    logic [7:0] q;
    status_hi_pins = 8'h08;
    status_lo_pins = 8'hf7;
    ready_pins = 8'ha5;
    for (int b = 0; b < 2; b++)
    begin
      upc_bit14_pin = b[0];
      repeat (5) @(negedge clock);
      cpu_u.io_op(1'b0, 8'h00, 8'h00, q);
      chk(24'(q[7]), 24'(b[0]));
    end
    cpu_u.io_op(1'b0, 8'h03, 8'h00, q);
    chk(24'({q[7], q[0]}), 24'h2);
    cpu_u.io_op(1'b0, 8'h20, 8'h00, q);
    chk(24'(q), 24'ha5);
    timer_read_data = 8'h6e;
    fork
      cpu_u.io_op(1'b0, 8'h1c, 8'h00, q);
      begin
        repeat (3) @(negedge clock);
        chk(24'({timer_data_select, timer_cmd_select}), 24'h2);
      end
    join
    chk(24'(q), 24'h6e);
    timer_read_data = 8'h91;
    fork
      cpu_u.io_op(1'b0, 8'h1d, 8'h00, q);
      begin
        repeat (3) @(negedge clock);
        chk(24'({timer_data_select, timer_cmd_select}), 24'h1);
      end
    join
    chk(24'(q), 24'h91);
    cpu_u.io_op(1'b0, 8'h15, 8'h00, q);
    chk(24'(q), 24'(undefined_read));
    $display("t_reads done");
  endtask
  task automatic t_refresh;
    int n, cs;
    logic [row_width-1:0] r0;
    gap(n, cs);
    r0 = refresh_row;
    gap(n, cs);
    chk(24'(n), 24'd256);
    chk(24'(cs), 24'd1);
    chk(24'({refresh_row_strobe, refresh_row}), 24'({1'b1, r0 + 7'h01}));
    $display("t_refresh done");
  endtask
  task automatic t_arb;
    int n, cs, low, worst;
    gap(n, cs);
    repeat (245) @(negedge clock);
    cpu_u.mem_op(1'b0, 20, low);
    gap(n, cs);
    chk(24'(n < 12), 24'd1);
    cpu_u.mem_op(1'b1, 1, low);
    chk(24'(low), 24'd2);
    worst = 0;
    for (int k = 246; k < 258; k++)
    begin
      gap(n, cs);
      repeat (k) @(negedge clock);
      cpu_u.mem_op(1'b1, 1, low);
      worst = (low > worst) ? low : worst;
    end
    chk(24'(worst > 2), 24'd1);
    $display("t_arb done");
  endtask

  initial
  begin
    upc_bit14_pin = 1'b0;
    status_hi_pins = 8'h00;
    status_lo_pins = 8'h00;
    ready_pins = 8'h00;
    timer_read_data = 8'h00;
    repeat (8) @(negedge clock);
    reset = 1'b0;
    t_cmds;
    t_reads;
    t_refresh;
    t_arb;
    finish_test;
  end
  // Whole run needs under 6500 cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    finish_test;
  end
endmodule // console_io_refresh_control_tb
